/* File: ctc_consts.svh */
/*
  Shared constants of the four-channel counter/timer: control word bit
  positions, reset values, opcode bytes and timing figures.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef CTC_CONSTS_SVH
`define CTC_CONSTS_SVH

// Control word bit positions.
`define CW_CTRL      0
`define CW_SRST      1
`define CW_TCF       2
`define CW_TRIG      3
`define CW_EDGE      4
`define CW_PRE       5
`define CW_MODE      6
`define CW_IE        7

// Reset values and byte constants.
`define CTRL_RST     8'h00
`define VEC_RST      8'h00
`define CNT_RST      8'h00
`define CNT_ONE      8'h01
`define PRE16_MASK   8'h0F
`define PRE_FULL     8'hFF
`define RETURN_FROM_IRQ_BYTE1   8'hED
`define RETURN_FROM_IRQ_BYTE2   8'h4D

// Strobe vector positions.
`define ACT_WR       0
`define ACT_RD       1
`define ACT_ACK      2
`define ACT_FETCH    3
`define ACT_IDLE     4'hF

// Start delay of an auto-triggered timer after its reload value.
`define CLK_PERIOD_NS 10
`define START_DLY_NS  20
`define START_DLY_CYC ((`START_DLY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: ctc_pkg.sv */
/*
  Types of the four-channel counter/timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctc_pkg;

  typedef struct packed {
    logic       ce_n;
    logic       io_request_n_n;
    logic       rd_n;
    logic       m1_n;
    logic [1:0] sel;
    logic [7:0] data;
    logic [3:0] trig;
    logic       priority_in;
  } bus_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b11,
    ST_ARMED = 2'b10
  } ch_state_t;

endpackage

/* File: ctc_sync.sv */
/*
  Two-flip-flop synchroniser for a vector of asynchronous pins.
  Assumes each bit is an independent level; skew between bits is
  tolerated by the user logic, which samples inside stable windows.
*/
module ctc_sync #(
  parameter int WIDTH = 19
) (
  // Clock and reset.
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // Pins in, synchronised copy out.
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule

/* File: ctc_channel.sv */
/*
  One counter/timer channel: control and reload registers, start logic
  and the 8-bit down-counter with automatic reload.
  Assumes a synchronised trigger level and shared prescaler tick pulses.
*/
module ctc_channel
  import ctc_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Register writes.
  input  wire logic       i_wr_ctrl,
  input  wire logic       i_wr_tc,
  input  wire logic [7:0] i_wdata,
  // Count sources.
  input  wire logic       i_trig,
  input  wire logic       i_pre16,
  input  wire logic       i_pre256,
  // Status.
  output logic [7:0]      o_count,
  output logic            o_zero,
  output logic            o_ie,
  output logic            o_tc_next
);
`include "ctc_consts.svh"

  ch_state_t  state_r;
  logic [7:0] ctrl_r;
  logic [7:0] tc_r;
  logic [7:0] cnt_r;
  logic [1:0] dly_r;
  logic       trig_q_r;
  logic       trig_edge;
  logic       tick;
  logic       dec;

  assign trig_edge = ctrl_r[`CW_EDGE] ? (i_trig & ~trig_q_r) : (~i_trig & trig_q_r); // R25
  assign tick      = ctrl_r[`CW_MODE] ? trig_edge                            // R4
                   : (ctrl_r[`CW_PRE] ? i_pre256 : i_pre16);                 // R2
  assign dec       = (state_r == ST_RUN) & tick;
  assign o_zero    = dec & (cnt_r == `CNT_ONE);
  assign o_count   = cnt_r;
  assign o_ie      = ctrl_r[`CW_IE];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_q_r <= 1'b0;
    end else begin
      trig_q_r <= i_trig;
    end
  end

  // Control and reload registers; a reload written mid-count waits here.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r    <= `CTRL_RST;                                                // R19
      tc_r      <= `CNT_RST;
      o_tc_next <= 1'b0;
    end else if (i_wr_ctrl) begin
      ctrl_r    <= i_wdata;                                                  // R20
      o_tc_next <= i_wdata[`CW_TCF];                                         // R15
    end else if (i_wr_tc) begin
      tc_r      <= i_wdata;                                                  // R17
      o_tc_next <= 1'b0;
    end
  end

  // Channel state: idle until a reload value, then delay, armed or running.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      dly_r   <= 2'b00;
    end else if (i_wr_ctrl && i_wdata[`CW_SRST]) begin
      state_r <= ST_IDLE;                                                    // R20 R21
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (i_wr_tc) begin
            dly_r <= 2'(`START_DLY_CYC);
            if (ctrl_r[`CW_MODE]) begin
              state_r <= ST_RUN;
            end else if (ctrl_r[`CW_TRIG]) begin
              state_r <= ST_ARMED;                                           // R6
            end else begin
              state_r <= ST_DELAY;                                           // R21
            end
          end
        end
        ST_DELAY: begin
          dly_r <= dly_r - 2'b01;
          if (dly_r == 2'b01) begin
            state_r <= ST_RUN;                                               // R24
          end
        end
        ST_ARMED: begin
          if (trig_edge) begin
            state_r <= ST_RUN;                                               // R6
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Down-counter: loaded on start, reloaded at zero; zero byte counts 256.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= `CNT_RST;
    end else if (i_wr_tc && state_r == ST_IDLE) begin
      cnt_r <= i_wdata;                                                      // R5
    end else if (dec) begin
      cnt_r <= (cnt_r == `CNT_ONE) ? tc_r : cnt_r - `CNT_ONE;                // R3 R5
    end
  end

  a_zero_reload: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    o_zero |=> cnt_r == $past(tc_r))
    else $error("counter did not reload at zero");

  a_srst_stops: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
    i_wr_ctrl && i_wdata[`CW_SRST] |=> state_r == ST_IDLE ##1 !dec)
    else $error("software reset did not stop the channel");

  a_reload_waits: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
    state_r == ST_RUN && i_wr_tc && !dec |=> cnt_r == $past(cnt_r))
    else $error("reload value disturbed a running count");

  a_auto_start: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R24
    state_r == ST_IDLE && i_wr_tc && !ctrl_r[`CW_MODE] && !ctrl_r[`CW_TRIG]
    && !i_wr_ctrl |=> state_r == ST_DELAY ##2 state_r == ST_RUN)
    else $error("auto-triggered timer did not start after two clocks");

endmodule

/* File: quad_ctc.sv */
/*
  Four-channel counter/timer with host I/O port and daisy-chained,
  vectored interrupts.
  Assumes an 8-bit host bus whose pins are asynchronous to i_ref_clk and
  whose cycles last several clocks; the data bus pin is resolved outside
  from o_data and o_data_oe, the interrupt line from o_irq_oe.
*/
// Summary of operation
// R1: Four channels, each set up by a control word then a reload value.
// R2: Timer mode counts prescaler ticks of 16 or 256 clocks per bit 5.
// R3: Reload byte gives 1 to 256 counts; zero means 256.
// R4: Counter mode decrements once per synchronised active trigger edge.
// R5: Counter loads reload value at start and again at every zero.
// R6: Timer starts automatically or on a trigger edge, as configured.
// R7: Channels 0 to 2 pulse their zero-count output; channel 3 has none.
// R8: Interrupt-enabled channel reaching zero asserts the low interrupt request.
// R9: Fixed priority, channel 0 highest, four adjacent daisy-chain slots.
// R10: High priority-in grants priority; priority-out low in service or when lost.
// R11: Pending interrupt drives priority-out low while it waits.
// R12: Opcode fetch plus I/O request acknowledges; device returns channel vector.
// R13: Return opcode first byte lifts priority-out for one fetch if pending.
// R14: Reading a channel port returns its live count undisturbed.
// R15: Bit 0 set marks control word; bit 2 announces reload; else vector.
// R16: One vector base; channel number inserted into the supplied vector.
// R17: New reload written mid-count waits until the count reaches zero.
// R18: Host selects a channel with the two-bit select code.
// R19: Reset stops counts, clears enables, idles outputs, floats data bus.
// R20: Bit 1 stops the channel until a new reload value arrives.
// R21: Stop with reload-follows halts; auto timer restarts on that value.
// R22: Interrupt enable may be changed by a control word at any time.
// R23: Write is I/O request with chip enable while read is inactive.
// R24: Auto timer begins counting two clocks after the reload write.
// R25: Bit 6 picks mode, bit 4 trigger edge, bit 3 trigger source.
module quad_ctc
  import ctc_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Host bus.
  input  wire logic       i_chip_en_n,
  input  wire logic       i_io_request_n,
  input  wire logic       i_read_n,
  input  wire logic       i_opcode_fetch_n,
  input  wire logic       i_chan_sel_hi,
  input  wire logic       i_chan_sel_lo,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // Interrupt daisy chain.
  input  wire logic       i_priority_in,
  output logic            o_priority_out,
  output logic            o_irq_n,
  output logic            o_irq_oe,
  // Channel pins.
  input  wire logic [3:0] i_ext_trigger_in,
  output logic      [2:0] o_zero_count_pulse
);
`include "ctc_consts.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and cycle decoding.

  bus_pins_t  raw;
  bus_pins_t  s;
  logic [3:0] act;
  logic [3:0] act_q_r;
  logic [3:0] rise;
  logic       fetch_end;

  assign raw = {i_chip_en_n, i_io_request_n, i_read_n, i_opcode_fetch_n,
                i_chan_sel_hi, i_chan_sel_lo, i_data, i_ext_trigger_in,
                i_priority_in};                                              // R18

  ctc_sync #(
    .WIDTH ($bits(bus_pins_t))
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_d       (raw),
    .o_q       (s)
  );

  assign act[`ACT_WR]    = !s.ce_n && !s.io_request_n_n && s.rd_n && s.m1_n;         // R23
  assign act[`ACT_RD]    = !s.ce_n && !s.io_request_n_n && !s.rd_n && s.m1_n;
  assign act[`ACT_ACK]   = !s.io_request_n_n && !s.m1_n;                             // R12
  assign act[`ACT_FETCH] = s.io_request_n_n && !s.m1_n && !s.rd_n;
  assign rise            = act & ~act_q_r;
  assign fetch_end       = act_q_r[`ACT_FETCH] & ~act[`ACT_FETCH];

  // The synchroniser resets to all zeros, which looks like an acknowledge;
  // starting the history at all ones keeps that from reading as a new cycle.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      act_q_r <= `ACT_IDLE;
    end else begin
      act_q_r <= act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler.

  logic [7:0] pre_r;
  logic       pre16;
  logic       pre256;

  assign pre16  = (pre_r & `PRE16_MASK) == `PRE16_MASK;                      // R2
  assign pre256 = pre_r == `PRE_FULL;                                        // R2

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_r <= `CNT_RST;
    end else begin
      pre_r <= pre_r + `CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels and write steering.

  logic [3:0] wr_ctrl;
  logic [3:0] wr_tc;
  logic [3:0] tc_next;
  logic [3:0] zero;
  logic [3:0] ie;
  logic [7:0] count [4];
  logic       wr_vec;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch                                     // R1
      assign wr_tc[g]   = rise[`ACT_WR] && s.sel == 2'(g) && tc_next[g];     // R15
      assign wr_ctrl[g] = rise[`ACT_WR] && s.sel == 2'(g) && !tc_next[g]
                          && s.data[`CW_CTRL];                               // R15
      ctc_channel u_ch (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_wr_ctrl (wr_ctrl[g]),
        .i_wr_tc   (wr_tc[g]),
        .i_wdata   (s.data),
        .i_trig    (s.trig[g]),
        .i_pre16   (pre16),
        .i_pre256  (pre256),
        .o_count   (count[g]),
        .o_zero    (zero[g]),
        .o_ie      (ie[g]),
        .o_tc_next (tc_next[g])
      );
    end
  endgenerate

  assign wr_vec = rise[`ACT_WR] && s.sel == 2'b00 && !tc_next[0] && !s.data[`CW_CTRL];

  ////////////////////////////////////////////////////////////////////////////
  // Zero-count pulses.

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_zero_count_pulse <= 3'b000;                                          // R19
    end else begin
      o_zero_count_pulse <= zero[2:0];                                       // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt logic.

  logic [7:0] vec_r;
  logic [3:0] pend_r;
  logic [3:0] insvc_r;
  logic [7:0] fetch_byte_r;
  logic       ed_win_r;
  logic       grant;
  logic       return_from_irq_done;
  logic [1:0] gidx;
  logic [1:0] sidx;

  function automatic logic [1:0] first_one(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'b00;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  assign gidx      = first_one(pend_r);                                      // R9
  assign sidx      = first_one(insvc_r);
  assign grant     = rise[`ACT_ACK] && s.priority_in && |pend_r && !(|insvc_r);      // R12
  assign return_from_irq_done = fetch_end && ed_win_r && fetch_byte_r == `RETURN_FROM_IRQ_BYTE2;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      vec_r <= `VEC_RST;
    end else if (wr_vec) begin
      vec_r <= s.data;                                                       // R16
    end
  end

  // A zero count in the same cycle as a grant still sets its pending bit.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= (pend_r & ~(grant ? 4'(1) << gidx : 4'h0)) | (zero & ie);     // R8 R22
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      insvc_r <= 4'h0;
    end else if (grant) begin
      insvc_r <= insvc_r | (4'(1) << gidx);
    end else if (return_from_irq_done) begin
      insvc_r <= insvc_r & ~(4'(1) << sidx);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fetch_byte_r <= `CNT_RST;
      ed_win_r     <= 1'b0;
    end else begin
      if (act[`ACT_FETCH]) begin
        fetch_byte_r <= s.data;
      end
      if (fetch_end) begin
        ed_win_r <= fetch_byte_r == `RETURN_FROM_IRQ_BYTE1;                             // R13
      end
    end
  end

  // Priority-out stays low while serviced, and while pending except after the
  // first return byte, so lower devices can see the second byte.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_priority_out <= 1'b0;
      o_irq_n        <= 1'b1;
      o_irq_oe       <= 1'b0;
    end else begin
      o_priority_out <= s.priority_in && !(|insvc_r) && (!(|pend_r) || ed_win_r);    // R10 R11 R13
      o_irq_n        <= !(s.priority_in && |pend_r);                                 // R8
      o_irq_oe       <= s.priority_in && |pend_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus drive: vector on acknowledge, live count on read.

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data    <= `CNT_RST;
      o_data_oe <= 1'b0;                                                     // R19
    end else if (grant) begin
      o_data    <= {vec_r[7:3], gidx, 1'b0};                                 // R12 R16
      o_data_oe <= 1'b1;
    end else if (act[`ACT_RD]) begin
      o_data    <= count[s.sel];                                             // R14
      o_data_oe <= 1'b1;
    end else if (!act[`ACT_ACK]) begin
      o_data_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_zero_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    zero[1] |=> o_zero_count_pulse[1] ##1 !o_zero_count_pulse[1] || zero[1])
    else $error("zero-count pulse missing");

  a_irq_raise: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    zero[3] && ie[3] && !grant |=> pend_r[3] ##1 (o_irq_n == !s.priority_in || !$stable(s.priority_in)))
    else $error("interrupt request not raised at zero");

  a_vector_out: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
    grant |=> o_data_oe && o_data[2:1] == $past(gidx) && o_data[7:3] == vec_r[7:3])
    else $error("wrong vector on acknowledge");

  a_prio_order: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
    grant && pend_r[1] && !pend_r[0] |=> insvc_r[1] && o_data[2:1] == 2'b01)
    else $error("channel 1 not served before lower channels");

  a_ieo_pending: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
    |pend_r && !ed_win_r |=> !o_priority_out)
    else $error("priority-out high while interrupt pending");

  a_iei_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R10
    !s.priority_in |=> !o_priority_out)
    else $error("priority-out high without priority-in");

  a_return_from_irq_lift: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
    ed_win_r && s.priority_in && !(|insvc_r) |=> o_priority_out)
    else $error("priority-out not lifted after first return byte");

  a_read_count: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
    act[`ACT_RD] && !grant |=> o_data_oe && o_data == $past(count[s.sel]))
    else $error("read did not return the live count");

endmodule

/* File: host_bus_model.sv */
/*
  Host processor model: I/O writes and reads, interrupt acknowledge,
  opcode fetches, the trigger pins and the daisy-chain input.
  Assumes the device samples every pin through synchronisers.
*/
module host_bus_model
  import ctc_pkg::*;
(
  // Clock.
  input  wire logic       i_ref_clk,
  // Device data bus.
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  // Pins to the device.
  output bus_pins_t       o_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 2'b00, 8'h00, 4'h0, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobes are {enable, request, read, fetch}, held five clocks.
  // A released data bus shows the inverse of its last value.
  task automatic cycle(input logic [3:0] s, input logic [1:0] ch,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic oe);
    @(posedge i_ref_clk);
    o_pins.sel  <= ch;
    o_pins.data <= d;
    repeat (2) @(posedge i_ref_clk);
    {o_pins.ce_n, o_pins.io_request_n_n, o_pins.rd_n, o_pins.m1_n} <= s;
    repeat (5) @(posedge i_ref_clk);
    q  = i_data;
    oe = i_data_oe;
    {o_pins.ce_n, o_pins.io_request_n_n, o_pins.rd_n, o_pins.m1_n} <= 4'hF;
    o_pins.data <= ~d;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    logic [7:0] q;
    logic       oe;
    cycle(4'b0011, ch, d, q, oe);
  endtask

  task automatic rd(input logic [1:0] ch, output logic [7:0] q, output logic oe);
    cycle(4'b0001, ch, ~o_pins.data, q, oe);
  endtask

  task automatic ack(output logic [7:0] q, output logic oe);
    cycle(4'b1010, 2'b00, ~o_pins.data, q, oe);
  endtask

  task automatic fetch(input logic [7:0] d);
    logic [7:0] q;
    logic       oe;
    cycle(4'b1100, 2'b00, d, q, oe);
  endtask

  task automatic pulse(input int ch);
    @(posedge i_ref_clk);
    o_pins.trig[ch] <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    o_pins.trig[ch] <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask

  task automatic set_iei(input logic v);
    @(posedge i_ref_clk);
    o_pins.priority_in <= v;
    repeat (4) @(posedge i_ref_clk);
  endtask
endmodule

/* File: quad_counter_timer_daisy_irq_tb.sv */
/*
  Self-checking bench of the four-channel counter/timer.
  Assumes the host model file is compiled first.
*/
module quad_counter_timer_daisy_irq_tb
  import ctc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  bus_pins_t  pins;
  logic [7:0] o_data;
  logic       o_data_oe;
  logic       o_priority_out;
  logic       o_irq_n;
  logic       o_irq_oe;
  logic [2:0] zc;
  int         n_fail = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         zc_n [3] = '{0, 0, 0};
  logic [7:0] q;
  logic       oe;
  int         g;
  int         n0;

  always #5 clk = ~clk;

  host_bus_model host (
    .i_ref_clk (clk),
    .i_data    (o_data),
    .i_data_oe (o_data_oe),
    .o_pins    (pins)
  );

  quad_ctc dut (
    .i_ref_clk          (clk),
    .i_rst              (rst),
    .i_chip_en_n        (pins.ce_n),
    .i_io_request_n     (pins.io_request_n_n),
    .i_read_n           (pins.rd_n),
    .i_opcode_fetch_n   (pins.m1_n),
    .i_chan_sel_hi      (pins.sel[1]),
    .i_chan_sel_lo      (pins.sel[0]),
    .i_data             (pins.data),
    .o_data             (o_data),
    .o_data_oe          (o_data_oe),
    .i_priority_in      (pins.priority_in),
    .o_priority_out     (o_priority_out),
    .o_irq_n            (o_irq_n),
    .o_irq_oe           (o_irq_oe),
    .i_ext_trigger_in   (pins.trig),
    .o_zero_count_pulse (zc)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Counts zero pulses per channel and cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (zc[i]) begin
        zc_n[i] <= zc_n[i] + 1;
      end
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_zc(input int ch, input int n);
    while (zc_n[ch] < n) @(negedge clk);
  endtask

  // Clocks between two successive zero pulses of a channel.
  task automatic gap(input int ch, output int gv);
    int t0;
    wait_zc(ch, zc_n[ch] + 1);
    t0 = cyc;
    wait_zc(ch, zc_n[ch] + 1);
    gv = cyc - t0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("data_oe", 16'h0, 16'(o_data_oe));
    chk("irq_n", 16'h1, 16'(o_irq_n));
    chk("zero pulses", 16'h0, 16'(zc));
    chk("priority_out", 16'h1, 16'(o_priority_out));
    $display("reset test done");
  endtask

  task automatic t_counter();
    host.wr(2'd0, 8'h55);
    host.wr(2'd0, 8'h01);
    host.pulse(0);
    chk("ch0 pulses", 16'h1, 16'(zc_n[0]));
    host.wr(2'd1, 8'h55);
    host.wr(2'd1, 8'h03);
    host.pulse(1);
    host.rd(2'd1, q, oe);
    chk("count", 16'h2, 16'(q));
    chk("read oe", 16'h1, 16'(oe));
    host.pulse(1);
    host.pulse(1);
    chk("ch1 pulses", 16'h1, 16'(zc_n[1]));
    host.rd(2'd1, q, oe);
    chk("reloaded", 16'h3, 16'(q));
    host.wr(2'd1, 8'h55);
    host.wr(2'd1, 8'h00);
    host.rd(2'd1, q, oe);
    chk("count kept", 16'h3, 16'(q));
    repeat (4) host.pulse(1);
    host.rd(2'd1, q, oe);
    chk("count of 256", 16'hFF, 16'(q));
    $display("counter test done");
  endtask

  task automatic t_timer();
    host.wr(2'd2, 8'h05);
    host.wr(2'd2, 8'h02);
    gap(2, g);
    gap(2, g);
    chk("gap by 16", 16'h20, 16'(g));
    host.wr(2'd2, 8'h25);
    host.wr(2'd2, 8'h01);
    gap(2, g);
    gap(2, g);
    chk("gap by 256", 16'h100, 16'(g));
    $display("timer test done");
  endtask

  task automatic t_stop();
    host.wr(2'd2, 8'h03);
    n0 = zc_n[2];
    repeat (600) @(posedge clk);
    chk("stopped", 16'(n0), 16'(zc_n[2]));
    host.wr(2'd2, 8'h0D);
    host.wr(2'd2, 8'h01);
    repeat (100) @(posedge clk);
    chk("armed", 16'(n0), 16'(zc_n[2]));
    host.pulse(2);
    gap(2, g);
    chk("triggered gap", 16'h10, 16'(g));
    $display("stop test done");
  endtask

  task automatic t_irq();
    host.wr(2'd0, 8'h40);
    host.wr(2'd3, 8'h85);
    host.wr(2'd3, 8'h01);
    host.wr(2'd1, 8'hD7);
    host.wr(2'd1, 8'h01);
    host.pulse(1);
    host.wr(2'd3, 8'h03);
    chk("irq_n", 16'h0, 16'(o_irq_n));
    chk("irq_oe", 16'h1, 16'(o_irq_oe));
    chk("pending chain", 16'h0, 16'(o_priority_out));
    host.set_iei(1'b0);
    host.ack(q, oe);
    chk("ack refused", 16'h0, 16'(oe));
    host.set_iei(1'b1);
    host.ack(q, oe);
    chk("vector ch1", 16'h42, 16'(q));
    chk("ack oe", 16'h1, 16'(oe));
    chk("in service", 16'h0, 16'(o_priority_out));
    host.fetch(8'hED);
    host.fetch(8'h4D);
    host.fetch(8'hED);
    repeat (3) @(posedge clk);
    chk("pending lift", 16'h1, 16'(o_priority_out));
    host.fetch(8'h4D);
    host.ack(q, oe);
    chk("vector ch3", 16'h46, 16'(q));
    host.fetch(8'hED);
    host.fetch(8'h4D);
    repeat (4) @(posedge clk);
    chk("chain freed", 16'h1, 16'(o_priority_out));
    chk("irq idle", 16'h1, 16'(o_irq_n));
    $display("interrupt test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_counter();
    t_timer();
    t_stop();
    t_irq();
    end_sim();
  end
endmodule
